// ==== serial_ctrl_map.svh ====
`ifndef SERIAL_CTRL_MAP_SVH
`define SERIAL_CTRL_MAP_SVH
`define PTR_LSB            0
`define PTR_MSB            2
`define CMD_LSB            3
`define CMD_MSB            5
`define CMD_CHAN_RESET     3'h3
`define CMD_RETURN_IRQ     3'h7
`define REG_CMD            3'h0
`define REG_IRQ_MODE       3'h1
`define REG_VECTOR         3'h2
`define REG_RX_PARAM       3'h3
`define REG_MISC           3'h4
`define REG_TX_PARAM       3'h5
`define WR1_SAV_BIT        2
`define WR1_TX_IE_BIT      1
`define WR1_RDY_EN_BIT     7
`define WR1_RDY_RX_BIT     5
`define OPCODE_PREFIX      8'hed
`define OPCODE_RETURN      8'h4d
`define TX_DELAY_MIN       5
`define TX_DELAY_MAX       9
`define RX_DELAY_MIN       10
`define RX_DELAY_MAX       13
`define TX_DELAY_CYC       4'h3
`define RX_DELAY_CYC       4'h8
`define VEC_CAUSE_LSB      1
`endif

// ==== serial_ctrl_pkg.sv ====
`default_nettype none
package serial_ctrl_pkg;
	typedef enum logic [1:0] {
		ACC_CMD = 2'b01,
		ACC_PTR = 2'b10
	} access_state_t;
endpackage : serial_ctrl_pkg
`default_nettype wire

// ==== edge_delay.sv ====
`default_nettype none
`include "serial_ctrl_map.svh"
module edge_delay (
	// Clock and control.
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// Trigger and delay.
	input  wire logic       trig,
	input  wire logic [3:0] delay,
	output logic            fire
);
	logic [3:0] count_reg;
	logic [3:0] count_next;
	logic       fire_reg;
	logic       fire_next;

	// Counts the number of clocks given on delay after a trigger, then pulses.
	always_comb begin
		count_next = count_reg;
		fire_next  = 1'b0;
		if (trig) begin
			count_next = delay;
		end else if (count_reg != 4'h0) begin
			count_next = count_reg - 4'h1;
			fire_next  = (count_reg == 4'h1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 4'h0;
			fire_reg  <= 1'b0;
		end else if (ce) begin
			count_reg <= count_next;
			fire_reg  <= fire_next;
		end
	end

	assign fire = fire_reg;
endmodule : edge_delay
`default_nettype wire

// ==== serial_ctrl_register_access.sv ====
// Notes on behaviour
// - Bus opcode ED then 4D ends in-service.
// - Return command in channel A does same.
// - Channel select and control/data pick the path.
// - Pointer byte then data byte writes registers.
// - Command field acts on single byte.
// - Any reset returns pointer to register zero.
// - Vector only in B, cause-modified readback.
// - Pointer byte selects next status read.
// - Status zero shows buffers, pending, externals.
// - Status one gathers all receive errors.
// - Registers one, three, four, five by function.
// - Transmit clock fall to ready, 5-9 clocks.
// - Transmit clock fall to interrupt, 5-9 clocks.
// - Receive clock rise to ready, 10-13 clocks.
// - Priority out follows in when idle.
// - Acknowledge with priority places vector, sets service.
`default_nettype none
`include "serial_ctrl_map.svh"
module serial_ctrl_register_access (
	// Clock, enable and reset.
	input  wire logic       MCLK,
	input  wire logic       CE,
	input  wire logic       RST_N,
	// Host bus.
	input  wire logic       CHAN_SEL,
	input  wire logic       CTRL_DATA,
	input  wire logic       WR_STB,
	input  wire logic       RD_STB,
	input  wire logic       M1_N,
	input  wire logic       IORQ_N,
	input  wire logic [7:0] DIN,
	output logic      [7:0] DOUT,
	output logic            DOUT_EN,
	// Channel status inputs.
	input  wire logic [1:0] TX_EMPTY,
	input  wire logic [1:0] RX_AVAIL,
	input  wire logic [5:0] EXT_STATUS_A,
	input  wire logic [5:0] EXT_STATUS_B,
	input  wire logic [7:0] RX_ERRORS_A,
	input  wire logic [7:0] RX_ERRORS_B,
	input  wire logic [2:0] IRQ_CAUSE,
	input  wire logic       TX_CLK_N,
	input  wire logic       RX_CLK,
	input  wire logic       RX_CHAR_DONE,
	// Daisy chain, interrupt and ready.
	input  wire logic       priority_chain_in,
	output logic            priority_chain_out,
	output logic            INT_N,
	output logic            WAIT_READY_N,
	// Configuration views.
	output logic      [7:0] IRQ_MODE_A,
	output logic      [7:0] IRQ_MODE_B,
	output logic      [7:0] RX_PARAM_A,
	output logic      [7:0] RX_PARAM_B,
	output logic      [7:0] MISC_MODE_A,
	output logic      [7:0] MISC_MODE_B,
	output logic      [7:0] TX_PARAM_A,
	output logic      [7:0] TX_PARAM_B,
	output logic      [1:0] CHAN_RESET
);
	logic [1:0] txc_sync_reg;
	logic [1:0] rxc_sync_reg;
	logic       txc_old_reg;
	logic       rxc_old_reg;
	logic [1:0] iei_sync_reg;
	logic       tx_fall;
	logic       rx_rise;
	logic       tx_fire;
	logic       rx_fire;
	serial_ctrl_pkg::access_state_t acc_reg [2];
	serial_ctrl_pkg::access_state_t acc_next [2];
	logic [2:0] ptr_reg [2];
	logic [2:0] ptr_next [2];
	logic [7:0] wreg_reg [2][6];
	logic [7:0] wreg_next [2][6];
	logic       prefix_reg, prefix_next;
	logic       in_service_reg, in_service_next;
	logic       tx_pend_reg, tx_pend_next;
	logic       int_n_reg, int_n_next;
	logic       rdy_n_reg, rdy_n_next;
	logic       ieo_reg, ieo_next;
	logic [7:0] dout_reg, dout_next;
	logic       dout_en_reg, dout_en_next;
	logic [1:0] reset_reg, reset_next;
	logic [7:0] rd_val;
	logic [2:0] rd_sel;
	logic       ch;
	logic       ret_irq;
	logic       ack;

	assign tx_fall = txc_old_reg & ~txc_sync_reg[1];
	assign rx_rise = ~rxc_old_reg & rxc_sync_reg[1] & RX_CHAR_DONE;
	assign ch      = CHAN_SEL;
	assign ack     = !M1_N && !IORQ_N;

	// Clock and chain pin inputs pass two flip-flops before use.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			txc_sync_reg <= 2'h3;
			rxc_sync_reg <= 2'h0;
			txc_old_reg  <= 1'b1;
			rxc_old_reg  <= 1'b0;
			iei_sync_reg <= 2'h0;
		end else if (CE) begin
			txc_sync_reg <= {txc_sync_reg[0], TX_CLK_N};
			rxc_sync_reg <= {rxc_sync_reg[0], RX_CLK};
			txc_old_reg  <= txc_sync_reg[1];
			rxc_old_reg  <= rxc_sync_reg[1];
			iei_sync_reg <= {iei_sync_reg[0], priority_chain_in};
		end
	end

	// Two synchronizer and one output stage are part of each delay.
	edge_delay u_tx_delay (
		.clk   (MCLK),
		.rst_n (RST_N),
		.ce    (CE),
		.trig  (tx_fall),
		.delay (`TX_DELAY_CYC),
		.fire  (tx_fire)
	);

	edge_delay u_rx_delay (
		.clk   (MCLK),
		.rst_n (RST_N),
		.ce    (CE),
		.trig  (rx_rise),
		.delay (`RX_DELAY_CYC),
		.fire  (rx_fire)
	);

	// Read mux for the selected status register.
	always_comb begin
		rd_sel = ptr_reg[ch];
		rd_val = 8'h00;
		if (rd_sel == 3'h1) begin
			rd_val = ch ? RX_ERRORS_B : RX_ERRORS_A;
		end else if (rd_sel == 3'h2 && ch) begin
			rd_val = wreg_reg[1][`REG_VECTOR];
			if (wreg_reg[1][`REG_IRQ_MODE][`WR1_SAV_BIT]) begin
				rd_val[`VEC_CAUSE_LSB +: 3] = IRQ_CAUSE;
			end
		end else begin
			rd_val = {ch ? EXT_STATUS_B : EXT_STATUS_A, TX_EMPTY[ch], RX_AVAIL[ch]};
			rd_val[1] = tx_pend_reg | in_service_reg;
			rd_val[2] = TX_EMPTY[ch];
			rd_val[0] = RX_AVAIL[ch];
		end
	end

	always_comb begin
		acc_next        = acc_reg;
		ptr_next        = ptr_reg;
		wreg_next       = wreg_reg;
		prefix_next     = prefix_reg;
		in_service_next = in_service_reg;
		tx_pend_next    = tx_pend_reg;
		int_n_next      = int_n_reg;
		rdy_n_next      = 1'b1;
		dout_next       = dout_reg;
		dout_en_next    = 1'b0;
		reset_next      = 2'h0;
		ret_irq         = 1'b0;
		if (WR_STB && CTRL_DATA) begin
			if (acc_reg[ch] == serial_ctrl_pkg::ACC_PTR) begin
				if (ptr_reg[ch] <= `REG_TX_PARAM) begin
					wreg_next[ch][ptr_reg[ch]] = DIN;
				end
				ptr_next[ch] = `REG_CMD;
				acc_next[ch] = serial_ctrl_pkg::ACC_CMD;
			end else begin
				wreg_next[ch][`REG_CMD] = DIN;
				ptr_next[ch] = DIN[`PTR_MSB:`PTR_LSB];
				if (DIN[`PTR_MSB:`PTR_LSB] != `REG_CMD) begin
					acc_next[ch] = serial_ctrl_pkg::ACC_PTR;
				end
				if (DIN[`CMD_MSB:`CMD_LSB] == `CMD_CHAN_RESET) begin
					ptr_next[ch]   = `REG_CMD;
					acc_next[ch]   = serial_ctrl_pkg::ACC_CMD;
					reset_next[ch] = 1'b1;
				end
				if (!ch && DIN[`CMD_MSB:`CMD_LSB] == `CMD_RETURN_IRQ) begin
					ret_irq = 1'b1;
				end
			end
		end
		if (RD_STB && CTRL_DATA) begin
			dout_next    = rd_val;
			dout_en_next = 1'b1;
			ptr_next[ch] = `REG_CMD;
			acc_next[ch] = serial_ctrl_pkg::ACC_CMD;
		end
		if (!M1_N && IORQ_N) begin
			prefix_next = (DIN == `OPCODE_PREFIX);
			if (prefix_reg && DIN == `OPCODE_RETURN) begin
				ret_irq = 1'b1;
			end
		end
		// Clears come first so that a set in the same cycle wins.
		if (ret_irq) begin
			in_service_next = 1'b0;
		end
		if (ack && iei_sync_reg[1] && tx_pend_reg) begin
			dout_next       = wreg_reg[1][`REG_VECTOR];
			dout_en_next    = 1'b1;
			in_service_next = 1'b1;
			tx_pend_next    = 1'b0;
			int_n_next      = 1'b1;
		end
		if (tx_fire && wreg_reg[1][`REG_IRQ_MODE][`WR1_TX_IE_BIT]) begin
			tx_pend_next = 1'b1;
			int_n_next   = 1'b0;
		end
		if (wreg_reg[1][`REG_IRQ_MODE][`WR1_RDY_EN_BIT]) begin
			if (wreg_reg[1][`REG_IRQ_MODE][`WR1_RDY_RX_BIT]) begin
				rdy_n_next = rdy_n_reg & ~rx_fire;
			end else begin
				rdy_n_next = rdy_n_reg & ~tx_fire;
			end
			if (WR_STB || RD_STB) begin
				rdy_n_next = 1'b1;
			end
		end
		ieo_next = iei_sync_reg[1] && !tx_pend_next && !in_service_next;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			for (int c = 0; c < 2; c++) begin
				acc_reg[c] <= serial_ctrl_pkg::ACC_CMD;
				ptr_reg[c] <= `REG_CMD;
				for (int r = 0; r < 6; r++) begin
					wreg_reg[c][r] <= 8'h00;
				end
			end
			prefix_reg     <= 1'b0;
			in_service_reg <= 1'b0;
			tx_pend_reg    <= 1'b0;
			int_n_reg      <= 1'b1;
			rdy_n_reg      <= 1'b1;
			ieo_reg        <= 1'b0;
			dout_reg       <= 8'h00;
			dout_en_reg    <= 1'b0;
			reset_reg      <= 2'h0;
		end else if (CE) begin
			acc_reg        <= acc_next;
			ptr_reg        <= ptr_next;
			wreg_reg       <= wreg_next;
			prefix_reg     <= prefix_next;
			in_service_reg <= in_service_next;
			tx_pend_reg    <= tx_pend_next;
			int_n_reg      <= int_n_next;
			rdy_n_reg      <= rdy_n_next;
			ieo_reg        <= ieo_next;
			dout_reg       <= dout_next;
			dout_en_reg    <= dout_en_next;
			reset_reg      <= reset_next;
		end
	end

	assign DOUT               = dout_reg;
	assign DOUT_EN            = dout_en_reg;
	assign INT_N              = int_n_reg;
	assign WAIT_READY_N       = rdy_n_reg;
	assign priority_chain_out = ieo_reg;
	assign CHAN_RESET         = reset_reg;
	assign IRQ_MODE_A         = wreg_reg[0][`REG_IRQ_MODE];
	assign IRQ_MODE_B         = wreg_reg[1][`REG_IRQ_MODE];
	assign RX_PARAM_A         = wreg_reg[0][`REG_RX_PARAM];
	assign RX_PARAM_B         = wreg_reg[1][`REG_RX_PARAM];
	assign MISC_MODE_A        = wreg_reg[0][`REG_MISC];
	assign MISC_MODE_B        = wreg_reg[1][`REG_MISC];
	assign TX_PARAM_A         = wreg_reg[0][`REG_TX_PARAM];
	assign TX_PARAM_B         = wreg_reg[1][`REG_TX_PARAM];
endmodule : serial_ctrl_register_access
`default_nettype wire

// ==== serial_ctrl_register_access_asserts.sv ====
`default_nettype none
module serial_ctrl_access_checker (
	// Watched ports.
	input wire logic       MCLK,
	input wire logic       RST_N,
	input wire logic       CE,
	input wire logic       RD_STB,
	input wire logic       CTRL_DATA,
	input wire logic       M1_N,
	input wire logic       IORQ_N,
	input wire logic       TX_CLK_N,
	input wire logic       RX_CLK,
	input wire logic       RX_CHAR_DONE,
	input wire logic       priority_chain_in,
	input wire logic       priority_chain_out,
	input wire logic       INT_N,
	input wire logic       WAIT_READY_N,
	input wire logic       DOUT_EN,
	input wire logic [7:0] IRQ_MODE_B,
	input wire logic [1:0] CHAN_RESET
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	chk_read_answer: assert property (RD_STB && CE && CTRL_DATA |=> DOUT_EN)
		else $error("read gave no data");
	chk_tx_irq_delay: assert property ($fell(TX_CLK_N) && INT_N && IRQ_MODE_B[1]
		|=> INT_N [*5] ##[1:4] !INT_N) else $error("transmit interrupt delay wrong");
	chk_tx_ready_delay: assert property ($fell(TX_CLK_N) && WAIT_READY_N && IRQ_MODE_B[7] && !IRQ_MODE_B[5]
		|=> WAIT_READY_N [*5] ##[1:4] !WAIT_READY_N) else $error("transmit ready delay wrong");
	chk_rx_ready_delay: assert property ($rose(RX_CLK) && RX_CHAR_DONE && WAIT_READY_N && IRQ_MODE_B[7]
		&& IRQ_MODE_B[5] |=> WAIT_READY_N [*8] ##1 WAIT_READY_N [*2] ##[1:3] !WAIT_READY_N)
		else $error("receive ready delay wrong");
	chk_ack_vector: assert property (!M1_N && !IORQ_N && !INT_N && priority_chain_in |-> ##[1:3] DOUT_EN)
		else $error("acknowledge gave no vector");
	chk_chain_hold: assert property (!INT_N ##1 !INT_N |-> !priority_chain_out)
		else $error("chain passed while pending");
	chk_reset_idle: assert property (disable iff (1'b0) !RST_N |=> INT_N && WAIT_READY_N && !DOUT_EN)
		else $error("outputs not idle in reset");
	chk_chan_reset_pulse: assert property (CHAN_RESET != 2'h0 |=> CHAN_RESET == 2'h0)
		else $error("channel reset pulse too long");
endmodule : serial_ctrl_access_checker
`default_nettype wire

// ==== host_cpu_model.sv ====
`default_nettype none
module host_cpu_model (
	// Clock.
	input  wire logic       clk,
	// Host bus.
	output logic            chan_sel,
	output logic            ctrl_data,
	output logic            wr_stb,
	output logic            rd_stb,
	output logic            m1_n,
	output logic            iorq_n,
	output logic      [7:0] din
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		{chan_sel, wr_stb, rd_stb, din} = 11'h0;
		{ctrl_data, m1_n, iorq_n} = 3'h7;
	end
	// One control access; the data lines are inverted once released.
	task automatic cyc(input logic ch, input logic w, input logic [7:0] d);
		@(negedge clk);
		chan_sel = ch;
		din = d;
		{wr_stb, rd_stb} = {w, !w};
		@(negedge clk);
		{wr_stb, rd_stb} = 2'h0;
		din = ~d;
	endtask : cyc
	// Acknowledge, or a two-byte opcode fetch.
	task automatic fetch(input logic ack, input logic [15:0] d);
		@(negedge clk);
		din = d[15:8];
		{m1_n, iorq_n} = {1'b0, !ack};
		if (!ack) begin
			@(negedge clk);
			din = d[7:0];
		end
		@(negedge clk);
		{m1_n, iorq_n} = 2'h3;
		din = ~din;
	endtask : fetch
endmodule : host_cpu_model
`default_nettype wire

// ==== serial_ctrl_register_access_bench.sv ====
`default_nettype none
module serial_ctrl_register_access_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic       MCLK, RST_N, CE, CHAN_SEL, CTRL_DATA, WR_STB, RD_STB, M1_N, IORQ_N, DOUT_EN, INT_N;
	logic       WAIT_READY_N, TX_CLK_N, RX_CLK, RX_CHAR_DONE, priority_chain_in, priority_chain_out;
	logic [7:0] DIN, DOUT, RX_ERRORS_A, RX_ERRORS_B, IRQ_MODE_A, IRQ_MODE_B, RX_PARAM_A, RX_PARAM_B;
	logic [7:0] MISC_MODE_A, MISC_MODE_B, TX_PARAM_A, TX_PARAM_B;
	logic [5:0] EXT_STATUS_A, EXT_STATUS_B;
	logic [1:0] TX_EMPTY, RX_AVAIL, CHAN_RESET;
	logic [2:0] IRQ_CAUSE;
	int         miscompares = 0;
	int         num_checks = 0;
	serial_ctrl_register_access serial_ctrl_register_access_i (.MCLK, .CE, .RST_N, .CHAN_SEL, .CTRL_DATA,
		.WR_STB, .RD_STB, .M1_N, .IORQ_N, .DIN, .DOUT, .DOUT_EN, .TX_EMPTY, .RX_AVAIL, .EXT_STATUS_A,
		.EXT_STATUS_B, .RX_ERRORS_A, .RX_ERRORS_B, .IRQ_CAUSE, .TX_CLK_N, .RX_CLK, .RX_CHAR_DONE,
		.priority_chain_in, .priority_chain_out, .INT_N, .WAIT_READY_N, .IRQ_MODE_A, .IRQ_MODE_B, .RX_PARAM_A,
		.RX_PARAM_B, .MISC_MODE_A, .MISC_MODE_B, .TX_PARAM_A, .TX_PARAM_B, .CHAN_RESET);
	host_cpu_model host_cpu_model_i (.clk(MCLK), .chan_sel(CHAN_SEL), .ctrl_data(CTRL_DATA), .wr_stb(WR_STB),
		.rd_stb(RD_STB), .m1_n(M1_N), .iorq_n(IORQ_N), .din(DIN));
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic close_out;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic t_config;
		int         regs [5] = '{4, 1, 2, 3, 5};
		logic [7:0] v [8];
		for (int c = 0; c < 2; c++) begin
			foreach (regs[k]) begin
				host_cpu_model_i.cyc(c[0], 1'b1, 8'(regs[k]));
				host_cpu_model_i.cyc(c[0], 1'b1, 8'(16 * regs[k] + c));
			end
		end
		v = '{IRQ_MODE_A, IRQ_MODE_B, RX_PARAM_A, RX_PARAM_B, MISC_MODE_A, MISC_MODE_B, TX_PARAM_A, TX_PARAM_B};
		for (int i = 0; i < 8; i++)
			chk("config view", 8'(16 * ((i < 2) ? 1 : i / 2 + 2) + i % 2), v[i]);
		$display("config done");
	endtask : t_config
	task automatic t_status;
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b0, 1'b0, 8'h00);
		chk("status1", RX_ERRORS_A, DOUT);
		host_cpu_model_i.cyc(1'b0, 1'b0, 8'h00);
		chk("status0", {EXT_STATUS_A[5:1], TX_EMPTY[0], 1'b0, RX_AVAIL[0]}, DOUT);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h02);
		host_cpu_model_i.cyc(1'b1, 1'b0, 8'h00);
		chk("vector", 8'h21, DOUT);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h04);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h02);
		host_cpu_model_i.cyc(1'b1, 1'b0, 8'h00);
		chk("vector cause", {4'h2, IRQ_CAUSE, 1'b1}, DOUT);
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h19);
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h40);
		chk("pointer reset", 8'h10, IRQ_MODE_A);
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h18);
		chk("chan reset", 8'h01, {6'h0, CHAN_RESET});
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b0, 1'b1, 8'h40);
		chk("pointer later", 8'h40, IRQ_MODE_A);
		$display("status done");
	endtask : t_status
	task automatic t_irq;
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h02);
		for (int k = 0; k < 2; k++) begin
			TX_CLK_N = 1'b0;
			repeat (4) @(negedge MCLK);
			chk("interrupt early", 8'h1, {7'h0, INT_N});
			repeat (10) @(negedge MCLK);
			TX_CLK_N = 1'b1;
			chk("interrupt", 8'h0, {7'h0, INT_N});
			chk("chain out", 8'h0, {7'h0, priority_chain_out});
			host_cpu_model_i.fetch(1'b1, 16'h0000);
			chk("ack vector", 8'h21, DOUT);
			if (k == 0)
				host_cpu_model_i.fetch(1'b0, 16'hed4d);
			else
				host_cpu_model_i.cyc(1'b0, 1'b1, 8'h38);
			repeat (4) @(negedge MCLK);
			chk("chain out", 8'h1, {7'h0, priority_chain_out});
		end
		$display("interrupt done");
	endtask : t_irq
	task automatic t_ready;
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h80);
		TX_CLK_N = 1'b0;
		repeat (4) @(negedge MCLK);
		chk("tx ready early", 8'h1, {7'h0, WAIT_READY_N});
		repeat (10) @(negedge MCLK);
		TX_CLK_N = 1'b1;
		chk("tx ready", 8'h0, {7'h0, WAIT_READY_N});
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'h01);
		host_cpu_model_i.cyc(1'b1, 1'b1, 8'ha0);
		RX_CLK = 1'b1;
		repeat (9) @(negedge MCLK);
		chk("rx ready early", 8'h1, {7'h0, WAIT_READY_N});
		repeat (9) @(negedge MCLK);
		RX_CLK = 1'b0;
		chk("rx ready", 8'h0, {7'h0, WAIT_READY_N});
		$display("ready done");
	endtask : t_ready
	initial begin
		MCLK = 1'b0;
		forever #20 MCLK = ~MCLK;
	end
	initial begin
		repeat (3000) @(posedge MCLK);
		miscompares++;
		close_out();
	end
	initial begin
		RST_N = 1'b0;
		{CE, TX_CLK_N, RX_CLK, RX_CHAR_DONE, priority_chain_in} = 5'h1b;
		{TX_EMPTY, RX_AVAIL, IRQ_CAUSE} = 7'h2d;
		{EXT_STATUS_A, EXT_STATUS_B, RX_ERRORS_A, RX_ERRORS_B} = 28'ha95_5ca3;
		repeat (3) @(negedge MCLK);
		RST_N = 1'b1;
		t_config();
		t_status();
		t_irq();
		t_ready();
		close_out();
	end
endmodule : serial_ctrl_register_access_bench
bind serial_ctrl_register_access serial_ctrl_access_checker serial_ctrl_access_checker_i (.MCLK, .RST_N, .CE,
	.RD_STB, .CTRL_DATA, .M1_N, .IORQ_N, .TX_CLK_N, .RX_CLK, .RX_CHAR_DONE, .priority_chain_in,
	.priority_chain_out, .INT_N, .WAIT_READY_N, .DOUT_EN, .IRQ_MODE_B, .CHAN_RESET);
`default_nettype wire
